// file: bench/lss_host_model.sv
// lss_host_model: serial master framing sixteen-bit words on the link pins
// assumes the device samples on falling and shifts on rising clock edges
`timescale 1ns/100ps
module lss_host_model (
	output logic o_frame_select_n,
	output logic o_sclk,
	output logic o_serial_in,
	input wire logic i_serial_out
);
	initial begin
		o_frame_select_n = 1'h1;
		o_sclk = 1'h0;
		o_serial_in = 1'h0;
	end
	// data moves on the rising edge so it holds a full half period past the fall
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		o_frame_select_n = 1'h0;
		#200;
		for (int i = 15; i >= 0; i--) begin
			o_sclk = 1'h1;
			o_serial_in = tx[i];
			#40 o_sclk = 1'h0;
			rx[i] = i_serial_out;
			#40;
		end
		o_frame_select_n = 1'h1;
		o_serial_in = 1'h0;
		#100;
	endtask
endmodule

// file: bench/lss_spi_port_assertions.sv
// lss_spi_port_assertions: pin-level checks of the serial port and modes
// assumes one system clock domain and the port list of lss_spi_port
`timescale 1ns/100ps
module lss_spi_port_assertions (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_frame_select_n,
	input wire logic i_sclk,
	input wire logic i_wake,
	input wire logic i_reset_n_pin,
	input wire logic [3:0] i_direct_ctrl_lines,
	input wire logic [3:0] i_fault_det,
	input wire logic o_serial_out,
	input wire logic o_serial_out_oe,
	input wire logic [3:0] o_power_outputs,
	input wire logic o_fault_flag_n_oe,
	input wire logic [3:0] o_sense_sel,
	input wire logic [1:0] o_mode
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_so_off; i_frame_select_n [*4] |-> !o_serial_out_oe; endproperty
	a_so_off: assert property (p_so_off) else $error("serial out driven while idle");
	property p_so_on; $fell(i_frame_select_n) |-> ##[1:4] o_serial_out_oe; endproperty
	a_so_on: assert property (p_so_on) else $error("serial out not enabled");
	// a change while the clock stays low means a shift off the rising edge
	property p_so_hold; (o_serial_out_oe && !i_sclk) [*5] |-> $stable(o_serial_out); endproperty
	a_so_hold: assert property (p_so_hold) else $error("serial out moved in low phase");
	property p_flag_on; (|i_fault_det && o_mode != 2'h0) |-> ##[0:3] o_fault_flag_n_oe; endproperty
	a_flag_on: assert property (p_flag_on) else $error("fault flag not pulled");
	property p_flag_off; (i_fault_det == 4'h0) [*4] |-> !o_fault_flag_n_oe; endproperty
	a_flag_off: assert property (p_flag_off) else $error("fault flag not released");
	property p_sleep; (o_mode == 2'h0) [*2] |-> o_power_outputs == 4'h0; endproperty
	a_sleep: assert property (p_sleep) else $error("output on in sleep");
	property p_cfg; (o_mode != 2'h1) [*2] |-> o_sense_sel == 4'h0; endproperty
	a_cfg: assert property (p_cfg) else $error("config kept outside normal");
	property p_fsafe; (o_mode == 2'h2 && i_fault_det == 4'h0 && $stable(i_direct_ctrl_lines)) [*6]
		|-> o_power_outputs == i_direct_ctrl_lines; endproperty
	a_fsafe: assert property (p_fsafe) else $error("outputs not following inputs");
	property p_rstpin; (!i_reset_n_pin && !i_wake && i_direct_ctrl_lines == 4'h0) [*5]
		|-> o_mode == 2'h0; endproperty
	a_rstpin: assert property (p_rstpin) else $error("not asleep under reset pin");
	property p_wake; $rose(i_wake) |-> ##[1:5] o_mode != 2'h0; endproperty
	a_wake: assert property (p_wake) else $error("wake pin did not wake");
endmodule
bind lss_spi_port lss_spi_port_assertions lss_chk_inst (.i_clk_sys, .i_rst_n, .i_frame_select_n,
	.i_sclk, .i_wake, .i_reset_n_pin, .i_direct_ctrl_lines, .i_fault_det, .o_serial_out,
	.o_serial_out_oe, .o_power_outputs, .o_fault_flag_n_oe, .o_sense_sel, .o_mode);

// file: bench/tb.sv
// tb: self-checking bench for lss_spi_port driven by a host serial master model
// assumes a 100 MHz system clock and a watchdog shortened to 200 cycles
`timescale 1ns/100ps
module tb;
	logic clk, rst_n, fs_n, sclk, si, so, so_oe, wake, rpin, strap, fl_oe, fl_n, s_oe;
	logic cv, crdy, vfail, pwm;
	logic [3:0] dir, flt, pwr, ssel;
	logic [1:0] mode;
	logic [15:0] stat, cw, rx;
	int failures, n_tests;
	wire so_w = so_oe ? so : 1'hz;
	// open-drain flag with a pull-up
	wire fl_w = fl_oe ? fl_n : 1'h1;
	lss_spi_port #(.WDOG_CYCLES(200)) lss_spi_port_inst (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_frame_select_n(fs_n), .i_sclk(sclk),
		.i_serial_in(si), .o_serial_out(so), .o_serial_out_oe(so_oe),
		.i_direct_ctrl_lines(dir), .i_wake(wake), .i_reset_n_pin(rpin),
		.i_watchdog_enable_strap(strap), .i_fault_det(flt), .i_vdd_fail(vfail),
		.i_status_word_bits(stat), .o_power_outputs(pwr), .o_fault_flag_n_oe(fl_oe),
		.o_fault_flag_n(fl_n), .o_sense_sel(ssel), .o_sense_oe(s_oe), .o_pwm_clk_src(pwm),
		.o_mode(mode), .o_cmd_valid(cv), .o_cmd_word(cw), .i_cmd_ready(crdy));
	lss_host_model lss_host_model_inst (.o_frame_select_n(fs_n), .o_sclk(sclk),
		.o_serial_in(si), .i_serial_out(so_w));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wt(input logic [1:0] m, input int n);
		int k;
		k = 0;
		while (mode !== m && k < n) begin
			step(1);
			k++;
		end
		if (mode !== m) begin
			failures++;
			finish_test;
		end
	endtask
	task automatic fr(input logic [15:0] w);
		lss_host_model_inst.xfer(w, rx);
		step(6);
	endtask
	task automatic t_wake;
		wake = 1'h1;
		wt(2'h1, 20);
		rpin = 1'h1;
		wake = 1'h0;
		step(5);
		chk("mode", 2'h1, mode);
	endtask
	task automatic t_link;
		stat = 16'hA5C3;
		fr(16'h0405);
		chk("status", 16'hA5C3, rx);
		chk("outputs", 4'h5, pwr);
		dir = 4'h2;
		step(5);
		chk("outputs", 4'h7, pwr);
		chk("pwm clock", 1'h0, pwm);
		fr(16'h0802);
		chk("outputs", 4'h5, pwr);
		dir = 4'h0;
		fr(16'h0C02);
		chk("sense", 4'h2, ssel);
		chk("sense oe", 1'h1, s_oe);
		fr(16'h0C00);
		chk("sense oe", 1'h0, s_oe);
	endtask
	task automatic t_buf;
		logic [15:0] q[$];
		crdy = 1'h0;
		fr(16'h7C11);
		fr(16'h7C22);
		fr(16'h7C33);
		crdy = 1'h1;
		#1;
		repeat (6) begin
			if (cv === 1'h1) q.push_back(cw);
			step(1);
		end
		chk("words", 16'h0002, q.size());
		chk("word", 16'h7C11, q[0]);
		chk("word", 16'h7C22, q[1]);
	endtask
	task automatic t_fault;
		flt = 4'h1;
		step(4);
		chk("flag", 1'h0, fl_w);
		flt = 4'h0;
		step(4);
		chk("flag", 1'h1, fl_w);
	endtask
	task automatic t_wdog;
		fr(16'h0C02);
		rpin = 1'h0;
		step(6);
		chk("mode", 2'h0, mode);
		chk("sense", 4'h0, ssel);
		chk("outputs", 4'h0, pwr);
		strap = 1'h1;
		rpin = 1'h1;
		wt(2'h1, 20);
		wt(2'h2, 400);
		dir = 4'h9;
		step(6);
		chk("outputs", 4'h9, pwr);
		chk("pwm clock", 1'h1, pwm);
		fr(16'h8000);
		chk("mode", 2'h1, mode);
		fr(16'h0000);
		fr(16'h9001);
		chk("mode", 2'h1, mode);
		vfail = 1'h1;
		step(4);
		chk("mode", 2'h2, mode);
		chk("outputs", 4'h9, pwr);
		vfail = 1'h0;
		step(4);
		chk("mode", 2'h1, mode);
	endtask
	initial begin
		rst_n = 1'h0;
		{wake, rpin, strap, crdy} = 4'h1;
		{dir, flt, stat} = 24'h0;
		vfail = 1'h0;
		failures = 0;
		n_tests = 0;
		step(2);
		rst_n = 1'h1;
		step(5);
		chk("mode", 2'h0, mode);
		t_wake;
		t_link;
		t_buf;
		t_fault;
		t_wdog;
		finish_test;
	end
endmodule

// file: include/lss_pkg.sv
// lss_pkg: constants and carrier types for the lamp switch serial control port
// assumes a 100 MHz system clock; serial clock and frame select arrive as pins
package lss_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 5;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 10;
	localparam int WD_BIT = 15;
	localparam int NCH = 4;
	localparam int SYS_CLK_MHZ = 100;
	// watchdog time in microseconds; arbitrary plain default
	localparam int WDOG_TIME_US = 1000;
	localparam int WDOG_CYC = WDOG_TIME_US * SYS_CLK_MHZ;
	// register addresses (decoded from the five-bit field)
	localparam logic [4:0] ADR_OUT_ON = 5'h01;
	localparam logic [4:0] ADR_DIR_DIS = 5'h02;
	localparam logic [4:0] ADR_SENSE = 5'h03;
	localparam logic [4:0] ADR_CFG = 5'h04;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [3:0] OUT_ON_RST = 4'h0;
	localparam logic [3:0] DIR_DIS_RST = 4'h0;
	localparam logic [3:0] SENSE_RST = 4'h0;
	localparam logic CFG_RST = 1'b0;
	typedef enum logic [1:0] {MD_SLEEP, MD_NORMAL, MD_FAILSAFE} lss_mode_t;
	typedef struct packed {
		logic wd;
		logic [4:0] addr;
		logic [9:0] data;
	} lss_cmd_t;
	typedef struct packed {
		logic [3:0] on;
		logic [3:0] dir_dis;
		logic [3:0] sense_sel;
		logic vdd_fail_en;
	} lss_cfg_t;
endpackage

// file: rtl/lss_buf2.sv
// lss_buf2: two-entry buffer with valid and ready on both sides
// assumes both sides on the system clock
`timescale 1ns/100ps
module lss_buf2 #(
	parameter int W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	logic [W-1:0] mem_ff [2];
	logic wp_ff, rp_ff;
	logic [1:0] cnt_ff;
	logic push, pop;

	assign o_in_ready = (cnt_ff != 2'h2);
	assign o_out_valid = (cnt_ff != 2'h0);
	assign o_out_data = mem_ff[rp_ff];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
		end else if (push) begin
			mem_ff[wp_ff] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push)
				wp_ff <= ~wp_ff;
			if (pop)
				rp_ff <= ~rp_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// file: rtl/lss_spi_port.sv
// lss_spi_port: serial port, wake, watchdog and fail-safe output logic
// assumes serial pins and direct inputs are asynchronous to i_clk_sys;
// fault and supply-loss indications come from same-clock logic
`timescale 1ns/100ps
module lss_spi_port
	import lss_pkg::*;
#(
	parameter int WDOG_CYCLES = lss_pkg::WDOG_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_frame_select_n,
	input wire logic i_sclk,
	input wire logic i_serial_in,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	input wire logic [3:0] i_direct_ctrl_lines,
	input wire logic i_wake,
	input wire logic i_reset_n_pin,
	input wire logic i_watchdog_enable_strap,
	input wire logic [3:0] i_fault_det,
	input wire logic i_vdd_fail,
	input wire logic [15:0] i_status_word_bits,
	output logic [3:0] o_power_outputs,
	output logic o_fault_flag_n_oe,
	output logic o_fault_flag_n,
	output logic [3:0] o_sense_sel,
	output logic o_sense_oe,
	output logic o_pwm_clk_src,
	output logic [1:0] o_mode,
	output logic o_cmd_valid,
	output logic [15:0] o_cmd_word,
	input wire logic i_cmd_ready
);
	// pin synchronisers: stage one feeds stage two only
	logic [8:0] s1_ff, s2_ff, s3_ff;
	logic cs_n, sck, sdi, rstp, wk;
	logic [3:0] din;
	lss_mode_t mode_ff;
	lss_cfg_t cfg_ff;
	logic [15:0] rx_ff, tx_ff;
	logic [4:0] bits_ff;
	logic wd_last_ff, wd_run_ff, wd_to_ff, strap_ff;
	logic [31:0] wd_cnt_ff;
	logic buf_in_valid, buf_in_ready, buf_out_valid;
	logic [15:0] buf_out_data;
	logic sck_rise, sck_fall, cs_fall, cs_rise, rst_rise, wake_up, fail;
	logic fault_ff, vfail_ff;
	logic take, wd_kick, wd_expired;
	lss_cmd_t cmd;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_ff <= 9'h001;
			s2_ff <= 9'h001;
			s3_ff <= 9'h001;
		end else begin
			s1_ff <= {i_direct_ctrl_lines, i_wake, i_reset_n_pin, i_serial_in, i_sclk,
				i_frame_select_n};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign cs_n = s2_ff[0];
	assign sck = s2_ff[1];
	assign sdi = s2_ff[2];
	assign rstp = s2_ff[3];
	assign wk = s2_ff[4];
	assign din = s2_ff[8:5];
	// edges compare stages two and three, never stage one
	assign sck_rise = sck && !s3_ff[1] && !cs_n;
	assign sck_fall = !sck && s3_ff[1] && !cs_n;
	assign cs_fall = !cs_n && s3_ff[0];
	assign cs_rise = cs_n && !s3_ff[0];
	assign rst_rise = rstp && !s3_ff[3];
	assign wake_up = rstp || wk || (|din);
	assign fail = (wd_to_ff && strap_ff) || vfail_ff || (i_vdd_fail && cfg_ff.vdd_fail_en);

	// strap caught after reset release, since it may not be sampled asynchronously
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			strap_ff <= 1'b1;
		else
			strap_ff <= i_watchdog_enable_strap;
	end

	// receive shift: msb first on falling serial clock
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			rx_ff <= '0;
		else if (sck_fall && !cs_fall)
			rx_ff <= {rx_ff[14:0], sdi};
	end

	// falling edges of the frame; stops at seventeen so a long frame stays marked bad
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			bits_ff <= '0;
		else if (cs_fall)
			bits_ff <= '0;
		else if (sck_fall && bits_ff != 5'h11)
			bits_ff <= bits_ff + 5'h01;
	end

	// transmit shift: status loaded at frame start, shifted on rising edges
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_ff <= STATUS_RST;
		end else if (cs_fall) begin
			tx_ff <= i_status_word_bits;
		end else if (sck_rise && bits_ff != 5'h00) begin
			tx_ff <= {tx_ff[14:0], 1'b0};
		end
	end

	// only whole sixteen-bit frames are committed; short or long ones are dropped
	assign buf_in_valid = cs_rise && bits_ff == 5'h10;
	assign o_serial_out = tx_ff[15];
	assign o_serial_out_oe = !cs_n;

	lss_buf2 #(
		.W(WORD_W)
	) u_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_in_valid(buf_in_valid),
		.o_in_ready(buf_in_ready),
		.i_in_data(rx_ff),
		.o_out_valid(buf_out_valid),
		.i_out_ready(i_cmd_ready),
		.o_out_data(buf_out_data)
	);

	// a frame arriving with both entries full is lost
	logic unused_ready;
	assign unused_ready = buf_in_ready;
	// a word acts only once the observer takes it, so a stall delays the register update
	assign take = buf_out_valid && i_cmd_ready;
	assign cmd = lss_cmd_t'(buf_out_data);

	// configuration registers: address decode of committed words
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_ff <= '{OUT_ON_RST, DIR_DIS_RST, SENSE_RST, CFG_RST};
		end else if (!rstp || mode_ff != MD_NORMAL) begin
			cfg_ff <= '{OUT_ON_RST, DIR_DIS_RST, SENSE_RST, CFG_RST};
		end else if (take) begin
			case (buf_out_data[ADDR_MSB:ADDR_LSB])
				ADR_OUT_ON: cfg_ff.on <= buf_out_data[3:0];
				ADR_DIR_DIS: cfg_ff.dir_dis <= buf_out_data[3:0];
				ADR_SENSE: cfg_ff.sense_sel <= buf_out_data[3:0];
				ADR_CFG: cfg_ff.vdd_fail_en <= buf_out_data[0];
				default: ;
			endcase
		end
	end

	// command words wait in the buffer while the observer stalls
	assign o_cmd_valid = buf_out_valid;
	assign o_cmd_word = buf_out_data;

	// watchdog run flag: started by a reset pin rise, only with the strap high
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			wd_run_ff <= 1'b0;
		else if (!rstp)
			wd_run_ff <= 1'b0;
		else if (rst_rise)
			wd_run_ff <= strap_ff;
	end

	// a kick is a change of bit fifteen in a taken word
	assign wd_kick = wd_run_ff && !rst_rise && take && cmd.wd != wd_last_ff;
	assign wd_expired = wd_cnt_ff >= 32'(WDOG_CYCLES - 1);

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			wd_last_ff <= 1'b0;
		else if (!rstp)
			wd_last_ff <= 1'b0;
		else if (wd_kick)
			wd_last_ff <= cmd.wd;
	end

	// counter holds at its end value until a kick, so the timeout stays set
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			wd_cnt_ff <= '0;
		else if (!rstp || rst_rise || wd_kick)
			wd_cnt_ff <= '0;
		else if (wd_run_ff && !wd_expired)
			wd_cnt_ff <= wd_cnt_ff + 32'h1;
	end

	// a kick writing one ends a timeout; it beats expiry since it came in time
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			wd_to_ff <= 1'b0;
		else if (!rstp)
			wd_to_ff <= 1'b0;
		else if (wd_kick)
			wd_to_ff <= wd_to_ff && !cmd.wd;
		else if (wd_run_ff && !rst_rise && wd_expired)
			wd_to_ff <= 1'b1;
	end

	// supply loss latches fail-safe, since fail-safe clears the enable that armed it
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			vfail_ff <= 1'b0;
		else if (i_vdd_fail && cfg_ff.vdd_fail_en)
			vfail_ff <= 1'b1;
		else if (!i_vdd_fail)
			vfail_ff <= 1'b0;
	end

	// mode selection
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			mode_ff <= MD_SLEEP;
		else if (!wake_up)
			mode_ff <= MD_SLEEP;
		else if (fail)
			mode_ff <= MD_FAILSAFE;
		else
			mode_ff <= MD_NORMAL;
	end

	// output drive per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_power_outputs[g] <= 1'b0;
				end else begin
					case (mode_ff)
						MD_SLEEP: o_power_outputs[g] <= 1'b0;
						MD_FAILSAFE: o_power_outputs[g] <= din[g] && !i_fault_det[g];
						MD_NORMAL: o_power_outputs[g] <= ((din[g] && !cfg_ff.dir_dis[g]) ||
							cfg_ff.on[g]) && !i_fault_det[g];
						default: o_power_outputs[g] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			fault_ff <= 1'b0;
		else
			fault_ff <= (|i_fault_det) && mode_ff != MD_SLEEP;
	end

	// open drain: only ever drive low
	assign o_fault_flag_n = 1'b0;
	assign o_fault_flag_n_oe = fault_ff;
	assign o_sense_sel = cfg_ff.sense_sel;
	assign o_sense_oe = |cfg_ff.sense_sel;
	assign o_pwm_clk_src = din[0];
	assign o_mode = mode_ff;
endmodule
